//--- common/lc_pkg.sv
// shared constants and types of the led current control register block
package lc_pkg;
    localparam int NCH   = 18;
    localparam int NDUTY = 72;
    localparam int NSC   = 36;
    localparam int GRP   = 6;

    // register addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_DUTY0  = 8'h01;
    localparam logic [7:0] A_DUTYN  = 8'h48;
    localparam logic [7:0] A_COMMIT = 8'h49;
    localparam logic [7:0] A_SC0    = 8'h4a;
    localparam logic [7:0] A_SCN    = 8'h6d;
    localparam logic [7:0] A_GAIN   = 8'h6e;
    localparam logic [7:0] A_PHASE  = 8'h70;
    localparam logic [7:0] A_DET    = 8'h71;
    localparam logic [7:0] A_FLT0   = 8'h72;
    localparam logic [7:0] A_FLT1   = 8'h73;
    localparam logic [7:0] A_FLT4   = 8'h76;
    localparam logic [7:0] A_TEMP   = 8'h77;
    localparam logic [7:0] A_SPRD   = 8'h78;
    localparam logic [7:0] A_RST    = 8'h7f;

    // command bytes, reset values and write masks
    localparam logic [7:0] CMD_GO    = 8'h00;
    localparam logic [7:0] CMD_RST   = 8'h00;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] PHASE_MSK = 8'hbf;
    localparam logic [7:0] TEMP_MSK  = 8'hc3;

    // field positions
    localparam int SSD_BIT   = 0;
    localparam int PDE_BIT   = 7;
    localparam int TFLAG_BIT = 4;

    typedef enum logic {DET_SHORT, DET_OPEN} lc_det_e;

    // byte-level request from the serial front end
    typedef struct packed {
        logic       set;
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } lc_req_s;

    typedef struct packed {
        logic [2:0] dc_n;
        logic       en;
        logic [1:0] range;
        logic [1:0] period;
    } lc_sprd_s;

    typedef struct packed {
        logic [1:0] derate;
        logic       rsv5;
        logic       flag;
        logic [1:0] rsv3;
        logic [1:0] thr;
    } lc_temp_s;
endpackage

//--- src/lc_regs.sv
// register file of the 18-channel led current controller
// How it works
// RL1: each output has four duty bytes, values A and B, low byte first
// RL2: zero written to commit, pin high and run bit set, copies duty shadow
// RL3: duty writes stay in shadow; other commit values are ignored
// RL4: each output has two scale bytes from 4ah onward, two per output
// RL5: scale writes act at once, no commit needed
// RL6: peak code is gain times the sum of both scales
// RL7: global gain byte resets to zero and scales every output
// RL8: phase bit 7 enables six-phase delay, register resets to zero
// RL9: each phase select bit picks 0 or 180 degrees
// RL10: mode 10 captures shorts once, 11 opens once, else nothing
// RL11: fault status holds only the latest detection kind
// RL12: one fault bit per output, unused upper bits read zero
// RL13: temperature bits 1:0 choose the roll-off start point
// RL14: temperature bits 7:6 choose the current kept during roll-off
// RL15: temperature bit 4 reads the over-threshold flag
// RL16: host rewrites threshold and level before reading temperature
// RL17: override bit per six-channel group, 0 forces full on
// RL18: full-on comes only from the override, duty untouched
// RL19: spread bit 4 enables spread spectrum
// RL20: spread bits 1:0 pick the modulation cycle time
// RL21: spread bits 3:2 pick the spread range
// RL22: zero written to the reset register restores every default
// RL23: control bit 0 low blanks all outputs
// RL24: pointer steps by one after each data byte
`timescale 1ns/1ps
module lc_regs (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire lc_pkg::lc_req_s        req_i,
    output logic [7:0]                  rdata_o,
    output logic                        rvalid_o,
    input  wire logic                   hw_shutdown_n_i,
    input  wire logic [17:0]            fault_raw_i,
    input  wire logic                   over_temp_i,
    output logic                        outputs_on_o,
    output logic [17:0][15:0]           duty_a_o,
    output logic [17:0][15:0]           duty_b_o,
    output logic [17:0]                 full_on_o,
    output logic [17:0][16:0]           peak_code_o,
    output logic                        phase_en_o,
    output logic [5:0]                  phase_sel_o,
    output logic                        det_start_o,
    output logic                        det_kind_o,
    output logic [1:0]                  derate_o,
    output logic [1:0]                  threshold_o,
    output logic                        spread_en_o,
    output logic [1:0]                  spread_range_o,
    output logic [1:0]                  spread_period_o
);

    function automatic logic is_duty(input logic [7:0] a);
        is_duty = (a >= lc_pkg::A_DUTY0) && (a <= lc_pkg::A_DUTYN);
    endfunction

    function automatic logic is_scale(input logic [7:0] a);
        is_scale = (a >= lc_pkg::A_SC0) && (a <= lc_pkg::A_SCN);
    endfunction

    // pin and analog inputs cross in through two flops
    logic        hw_s1, hw_q, ot_s1, ot_q;
    logic [17:0] flt_s1, flt_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hw_s1  <= 1'b0;
            hw_q   <= 1'b0;
            ot_s1  <= 1'b0;
            ot_q   <= 1'b0;
            flt_s1 <= 18'h0;
            flt_q  <= 18'h0;
        end
        else
        begin
            hw_s1  <= hw_shutdown_n_i;
            hw_q   <= hw_s1;
            ot_s1  <= over_temp_i;
            ot_q   <= ot_s1;
            flt_s1 <= fault_raw_i;
            flt_q  <= flt_s1;
        end
    end

    // register state
    logic [7:0]            ctrl_r, ctrl_nxt;
    logic [71:0][7:0]      sh_r, sh_nxt;
    logic [71:0][7:0]      act_r, act_nxt;
    logic [35:0][7:0]      sc_r, sc_nxt;
    logic [7:0]            gain_r, gain_nxt;
    logic [7:0]            phase_r, phase_nxt;
    logic [1:0]            det_r, det_nxt;
    logic [17:0]           flt_r, flt_nxt;
    lc_pkg::lc_det_e       kind_r, kind_nxt;
    lc_pkg::lc_temp_s      temp_r, temp_nxt;
    lc_pkg::lc_sprd_s      sprd_r, sprd_nxt;
    logic [7:0]            ptr_r, ptr_nxt;
    logic [7:0]            rdata_r, rdata_nxt;
    logic                  rvalid_r, rvalid_nxt;
    logic                  detgo_r, detgo_nxt;
    logic [7:0]            rd_mux;
    logic [7:0]            didx, sidx;

    assign didx = req_i.wr ? ptr_r - lc_pkg::A_DUTY0 : 8'h0;
    assign sidx = req_i.wr ? ptr_r - lc_pkg::A_SC0 : 8'h0;

    // read decode; shadow duty bytes read back, commit and reset read zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (ptr_r == lc_pkg::A_CTRL)
            rd_mux = ctrl_r;
        else if (is_duty(ptr_r))
            rd_mux = sh_r[ptr_r - lc_pkg::A_DUTY0];
        else if (is_scale(ptr_r))
            rd_mux = sc_r[ptr_r - lc_pkg::A_SC0];
        else if (ptr_r == lc_pkg::A_GAIN)
            rd_mux = gain_r;
        else if (ptr_r == lc_pkg::A_PHASE)
            rd_mux = phase_r;
        else if (ptr_r == lc_pkg::A_DET)
            rd_mux = {6'h00, det_r};
        else if (ptr_r == lc_pkg::A_FLT0)
            rd_mux = flt_r[7:0];                                   // RL12
        else if (ptr_r == lc_pkg::A_FLT1)
            rd_mux = flt_r[15:8];                                  // RL12
        else if (ptr_r == lc_pkg::A_FLT4)
            rd_mux = {6'h00, flt_r[17:16]};                        // RL12
        else if (ptr_r == lc_pkg::A_TEMP)
        begin
            rd_mux = temp_r;
            rd_mux[lc_pkg::TFLAG_BIT] = ot_q;                      // RL15
        end
        else if (ptr_r == lc_pkg::A_SPRD)
            rd_mux = sprd_r;
    end

    // next-state of the register file; reset overrides the whole write, soft reset all but the pointer step
    always_comb
    begin
        ctrl_nxt   = ctrl_r;
        sh_nxt     = sh_r;
        act_nxt    = act_r;
        sc_nxt     = sc_r;
        gain_nxt   = gain_r;
        phase_nxt  = phase_r;
        det_nxt    = det_r;
        flt_nxt    = flt_r;
        kind_nxt   = kind_r;
        temp_nxt   = temp_r;
        sprd_nxt   = sprd_r;
        ptr_nxt    = ptr_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        detgo_nxt  = 1'b0;
        if (req_i.set)
            ptr_nxt = req_i.data;
        else if (req_i.wr)
        begin
            ptr_nxt = ptr_r + 8'h01;                               // RL24
            if (ptr_r == lc_pkg::A_CTRL)
                ctrl_nxt = req_i.data;                             // RL23
            else if (is_duty(ptr_r))
                sh_nxt[didx] = req_i.data;                         // RL1 RL3
            else if (ptr_r == lc_pkg::A_COMMIT)
            begin
                // only an exact zero, while powered and running, commits
                if (req_i.data == lc_pkg::CMD_GO && hw_q
                    && ctrl_r[lc_pkg::SSD_BIT])
                    act_nxt = sh_r;                                // RL2 RL3
            end
            else if (is_scale(ptr_r))
                sc_nxt[sidx] = req_i.data;                         // RL4 RL5
            else if (ptr_r == lc_pkg::A_GAIN)
                gain_nxt = req_i.data;                             // RL7
            else if (ptr_r == lc_pkg::A_PHASE)
                phase_nxt = req_i.data & lc_pkg::PHASE_MSK;        // RL8
            else if (ptr_r == lc_pkg::A_DET)
            begin
                det_nxt = req_i.data[1:0];
                // one capture per write; the kind replaces any older result
                if (req_i.data[1])
                begin
                    flt_nxt   = flt_q;                             // RL10
                    kind_nxt  = lc_pkg::lc_det_e'(req_i.data[0]);  // RL11
                    detgo_nxt = 1'b1;
                end
            end
            else if (ptr_r == lc_pkg::A_TEMP)
                temp_nxt = req_i.data & lc_pkg::TEMP_MSK;          // RL13 RL14
            else if (ptr_r == lc_pkg::A_SPRD)
                sprd_nxt = req_i.data;                             // RL19 RL20 RL21
        end
        else if (req_i.rd)
        begin
            rdata_nxt  = rd_mux;
            rvalid_nxt = 1'b1;
            ptr_nxt    = ptr_r + 8'h01;                            // RL24
        end
        if (rst_i || (req_i.wr && !req_i.set && ptr_r == lc_pkg::A_RST
                      && req_i.data == lc_pkg::CMD_RST))
        begin
            ctrl_nxt  = lc_pkg::RST_BYTE;                          // RL22
            sh_nxt    = '0;
            act_nxt   = '0;
            sc_nxt    = '0;
            gain_nxt  = lc_pkg::RST_BYTE;
            phase_nxt = lc_pkg::RST_BYTE;
            det_nxt   = 2'b00;
            flt_nxt   = 18'h0;
            kind_nxt  = lc_pkg::DET_SHORT;
            temp_nxt  = lc_pkg::RST_BYTE;
            sprd_nxt  = lc_pkg::RST_BYTE;
            detgo_nxt = 1'b0;
        end
        if (rst_i)
        begin
            ptr_nxt    = 8'h00;
            rdata_nxt  = 8'h00;
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        ctrl_r   <= ctrl_nxt;
        sh_r     <= sh_nxt;
        act_r    <= act_nxt;
        sc_r     <= sc_nxt;
        gain_r   <= gain_nxt;
        phase_r  <= phase_nxt;
        det_r    <= det_nxt;
        flt_r    <= flt_nxt;
        kind_r   <= kind_nxt;
        temp_r   <= temp_nxt;
        sprd_r   <= sprd_nxt;
        ptr_r    <= ptr_nxt;
        rdata_r  <= rdata_nxt;
        rvalid_r <= rvalid_nxt;
        detgo_r  <= detgo_nxt;
    end

    // output group: derived values registered so data outputs are flops
    logic                   on_r, on_nxt;
    logic [17:0][15:0]      da_r, da_nxt, db_r, db_nxt;
    logic [17:0]            full_r, full_nxt;
    logic [17:0][16:0]      pk_r, pk_nxt;
    logic [8:0]             ssum;

    always_comb
    begin
        ssum   = 9'h0;
        on_nxt = hw_q && ctrl_r[lc_pkg::SSD_BIT];                  // RL23
        for (int c = 0; c < lc_pkg::NCH; c++)
        begin
            da_nxt[c] = {act_r[4*c+1], act_r[4*c]};                // RL1
            db_nxt[c] = {act_r[4*c+3], act_r[4*c+2]};              // RL1
            // table polarity: a clear bit forces the group fully on
            full_nxt[c] = !sprd_r.dc_n[c / lc_pkg::GRP];           // RL17 RL18
            ssum = {1'b0, sc_r[2*c]} + {1'b0, sc_r[2*c+1]};
            // widen both factors first so the product keeps all 17 bits
            pk_nxt[c] = {9'h000, gain_r} * {8'h00, ssum};          // RL6 RL7
        end
        if (rst_i)
        begin
            on_nxt   = 1'b0;
            da_nxt   = '0;
            db_nxt   = '0;
            full_nxt = '0;
            pk_nxt   = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        on_r   <= on_nxt;
        da_r   <= da_nxt;
        db_r   <= db_nxt;
        full_r <= full_nxt;
        pk_r   <= pk_nxt;
    end

    assign rdata_o         = rdata_r;
    assign rvalid_o        = rvalid_r;
    assign outputs_on_o    = on_r;
    assign duty_a_o        = da_r;
    assign duty_b_o        = db_r;
    assign full_on_o       = full_r;
    assign peak_code_o     = pk_r;
    assign phase_en_o      = phase_r[lc_pkg::PDE_BIT];             // RL8
    assign phase_sel_o     = phase_r[5:0];                         // RL9
    assign det_start_o     = detgo_r;
    assign det_kind_o      = kind_r;
    assign derate_o        = temp_r.derate;                        // RL14
    assign threshold_o     = temp_r.thr;                           // RL13 RL16
    assign spread_en_o     = sprd_r.en;                            // RL19
    assign spread_range_o  = sprd_r.range;                         // RL21
    assign spread_period_o = sprd_r.period;                        // RL20

    // all checks run on the one clock and pause while reset is held
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic wr_go;
    assign wr_go = req_i.wr && !req_i.set;

    a_commit_copy: assert property (                               // RL2
        wr_go && ptr_r == lc_pkg::A_COMMIT && req_i.data == 8'h00
        && hw_q && ctrl_r[0] |=> act_r == $past(sh_r))
        else $error("commit did not copy shadow");
    a_commit_block: assert property (                              // RL3
        wr_go && ptr_r == lc_pkg::A_COMMIT && (req_i.data != 8'h00
        || !hw_q || !ctrl_r[0]) |=> $stable(act_r))
        else $error("refused commit changed duty");
    a_duty_shadowed: assert property (                             // RL3
        wr_go && is_duty(ptr_r) |=> $stable(act_r) ##1 da_r == $past(da_r))
        else $error("duty write reached outputs");
    a_scale_now: assert property (                                 // RL5
        wr_go && ptr_r == 8'h4b |=> sc_r[1] == $past(req_i.data))
        else $error("scale write not immediate");
    a_ptr_step: assert property (                                  // RL24
        (req_i.wr || req_i.rd) && !req_i.set |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer did not step");
    a_soft_reset: assert property (                                // RL22
        wr_go && ptr_r == lc_pkg::A_RST && req_i.data == 8'h00
        |=> gain_r == 8'h00 && act_r == '0 && ctrl_r == 8'h00 && sprd_r == 8'h00)
        else $error("soft reset left a register");
    a_open_capture: assert property (                              // RL10
        wr_go && ptr_r == lc_pkg::A_DET && req_i.data[1:0] == 2'b11
        |=> flt_r == $past(flt_q) && kind_r == lc_pkg::DET_OPEN && det_start_o)
        else $error("open detect not captured");
    a_no_detect: assert property (                                 // RL10
        wr_go && ptr_r == lc_pkg::A_DET && !req_i.data[1]
        |=> $stable(flt_r) && !det_start_o)
        else $error("disabled detect captured");
    a_temp_flag: assert property (                                 // RL15
        req_i.rd && !req_i.wr && !req_i.set && ptr_r == lc_pkg::A_TEMP
        |=> rvalid_o && rdata_o[4] == $past(ot_q))
        else $error("temperature flag wrong");
    a_group_full: assert property (                                // RL17
        !sprd_r.dc_n[2] |=> full_on_o[17] && full_on_o[12])
        else $error("override did not force full on");
    a_blank: assert property (                                     // RL23
        !ctrl_r[0] |=> !outputs_on_o)
        else $error("outputs on in soft shutdown");
    a_peak_code: assert property (                                 // RL6
        $stable(gain_r) && $stable(sc_r) |=> peak_code_o[0]
        == 17'($past(gain_r)) * (17'($past(sc_r[0])) + 17'($past(sc_r[1]))))
        else $error("peak code wrong");
    // a short capture must replace any earlier open result
    a_short_capture: assert property (                             // RL11
        wr_go && ptr_r == lc_pkg::A_DET && req_i.data[1:0] == 2'b10
        |=> flt_r == $past(flt_q) && kind_r == lc_pkg::DET_SHORT && det_start_o)
        else $error("short detect not captured");
    // the last status byte carries outputs 17:16 only
    a_status_upper: assert property (                              // RL12
        req_i.rd && !req_i.wr && !req_i.set && ptr_r == lc_pkg::A_FLT4
        |=> rvalid_o && rdata_o == {6'h00, $past(flt_r[17:16])})
        else $error("status upper bits wrong");
    // phase enable and selects follow the written byte directly
    a_phase_sel: assert property (                                 // RL9
        wr_go && ptr_r == lc_pkg::A_PHASE |=> phase_sel_o == $past(req_i.data[5:0])
        && phase_en_o == $past(req_i.data[7]))
        else $error("phase fields wrong");

    c_commit: cover property (
        wr_go && ptr_r == lc_pkg::A_COMMIT && req_i.data == 8'h00 && hw_q && ctrl_r[0]);
    c_open_det: cover property (det_start_o && kind_r == lc_pkg::DET_OPEN);
    c_soft_rst: cover property (wr_go && ptr_r == lc_pkg::A_RST && req_i.data == 8'h00);
    c_burst: cover property (wr_go [*4]);
    c_short_det: cover property (det_start_o && kind_r == lc_pkg::DET_SHORT);

endmodule // lc_regs

//--- tb/lc_host_model.sv
// host model: issues pointer, write and read byte requests to the register block
`timescale 1ns/1ps
module lc_host_model (
    input  wire logic       clk_i,
    output lc_pkg::lc_req_s req_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i
);
    // idle bus carries the inverted last byte so stale data never looks fresh
    initial req_o = '{set: 1'b0, wr: 1'b0, rd: 1'b0, data: 8'h00};

    // one request pulse, launched and withdrawn on falling edges
    task automatic put(input logic s, input logic w, input logic r, input logic [7:0] d);
        @(negedge clk_i);
        req_o <= '{set: s, wr: w, rd: r, data: d};
        @(negedge clk_i);
        req_o <= '{set: 1'b0, wr: 1'b0, rd: 1'b0, data: ~d};
    endtask

    // pointer load then one data byte
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, 1'b0, 1'b0, a);
        put(1'b0, 1'b1, 1'b0, d);
    endtask

    // four bytes in one transfer, relying on the pointer stepping on its own
    task automatic wburst(input logic [7:0] a, input logic [31:0] b);
        put(1'b1, 1'b0, 1'b0, a);
        for (int i = 0; i < 4; i++)
            put(1'b0, 1'b1, 1'b0, b[8*i +: 8]);
    endtask

    // rvalid stands only in the cycle after the request edge: taken where put returns
    task automatic rreg(input logic [7:0] a, output logic [7:0] d, output logic v);
        put(1'b1, 1'b0, 1'b0, a);
        put(1'b0, 1'b0, 1'b1, 8'h00);
        v = rvalid_i;
        d = rdata_i;
    endtask

    // temperature read always preceded by rewriting level and threshold
    task automatic temp_read(input logic [1:0] lvl, input logic [1:0] thr,
                             output logic [7:0] d, output logic v);
        wreg(lc_pkg::A_TEMP, {lvl, 4'h0, thr});
        rreg(lc_pkg::A_TEMP, d, v);
    endtask
endmodule // lc_host_model

//--- tb/test_lc_regs.sv
// self-checking bench of the led current control register block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_lc_regs;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdat;
        logic [7:0] rexp;
    } lc_row_s;

    logic             clk_i;
    logic             rst_i;
    lc_pkg::lc_req_s  req;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             hw_shutdown_n;
    logic [17:0]      fault_raw;
    logic             over_temp;
    logic             outputs_on;
    logic [17:0][15:0] duty_a;
    logic [17:0][15:0] duty_b;
    logic [17:0]      full_on;
    logic [17:0][16:0] peak;
    logic             phase_en;
    logic [5:0]       phase_sel;
    logic             det_kind;
    logic             det_start;
    int               n_det = 0;
    logic [1:0]       derate;
    logic [1:0]       thr;
    logic             spread_en;
    logic [1:0]       spread_range;
    logic [1:0]       spread_period;
    int               failures = 0;
    int               n_checks = 0;
    logic [7:0]       d;
    logic             v;

    // plain register cases: address, byte written, byte read back
    lc_row_s rows [11] = '{
        '{lc_pkg::A_CTRL, 8'h01, 8'h01}, '{lc_pkg::A_SC0, 8'ha5, 8'ha5},
        '{lc_pkg::A_SCN, 8'h3c, 8'h3c}, '{lc_pkg::A_GAIN, 8'h81, 8'h81},
        '{lc_pkg::A_PHASE, 8'hff, 8'hbf}, '{lc_pkg::A_DET, 8'h01, 8'h01},
        '{lc_pkg::A_TEMP, 8'hff, 8'hc3}, '{lc_pkg::A_SPRD, 8'hdb, 8'hdb},
        '{8'h6f, 8'hff, 8'h00}, '{8'h79, 8'hff, 8'h00},
        '{lc_pkg::A_COMMIT, 8'h5a, 8'h00}};

    lc_regs lc_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .hw_shutdown_n_i(hw_shutdown_n), .fault_raw_i(fault_raw), .over_temp_i(over_temp),
        .outputs_on_o(outputs_on), .duty_a_o(duty_a), .duty_b_o(duty_b),
        .full_on_o(full_on), .peak_code_o(peak), .phase_en_o(phase_en),
        .phase_sel_o(phase_sel), .det_start_o(det_start), .det_kind_o(det_kind),
        .derate_o(derate), .threshold_o(thr), .spread_en_o(spread_en),
        .spread_range_o(spread_range), .spread_period_o(spread_period)
    );

    lc_host_model lc_host_model_inst (
        .clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid)
    );

    // 250 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic finish_test;
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // derived outputs lag a write by two edges, three falling edges cover it
    task automatic settle;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] rd;
        logic       ok;
        lc_host_model_inst.rreg(a, rd, ok);
        `CHK(ok, 1'b1)
        `CHK(rd, e)
    endtask

    // count detect pulses mid-cycle; each one stands a single cycle
    always @(negedge clk_i)
        if (det_start === 1'b1)
            n_det++;

    // a hang is cut short well beyond the expected run of under 2000 cycles
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end

    // main sequence
    initial
    begin
        rst_i = 1'b1;
        hw_shutdown_n = 1'b1;
        fault_raw = 18'h0;
        over_temp = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        settle();
        `CHK(full_on, 18'h3ffff)
        `CHK(outputs_on, 1'b0)
        chk_rd(lc_pkg::A_GAIN, 8'h00);
        chk_rd(lc_pkg::A_PHASE, 8'h00);
        chk_rd(lc_pkg::A_SPRD, 8'h00);
        foreach (rows[i])
        begin
            lc_host_model_inst.wreg(rows[i].addr, rows[i].wdat);
            chk_rd(rows[i].addr, rows[i].rexp);
        end
        settle();
        `CHK({phase_en, phase_sel}, 7'h7f)
        `CHK({derate, thr}, 4'hf)
        `CHK({spread_en, spread_range, spread_period}, 5'h1b)
        `CHK(full_on, 18'h0003f)
        `CHK(outputs_on, 1'b1)
        // duty goes to shadow, nonzero or gated commits are ignored
        lc_host_model_inst.wburst(lc_pkg::A_DUTY0, 32'h5678_1234);
        lc_host_model_inst.wburst(8'h45, 32'hdead_beef);
        lc_host_model_inst.wreg(lc_pkg::A_COMMIT, 8'h01);
        settle();
        `CHK(duty_a[0], 16'h0000)
        lc_host_model_inst.wreg(lc_pkg::A_CTRL, 8'h00);
        lc_host_model_inst.wreg(lc_pkg::A_COMMIT, 8'h00);
        settle();
        `CHK(duty_a[0], 16'h0000)
        `CHK(outputs_on, 1'b0)
        hw_shutdown_n = 1'b0;
        lc_host_model_inst.wreg(lc_pkg::A_CTRL, 8'h01);
        settle();
        lc_host_model_inst.wreg(lc_pkg::A_COMMIT, 8'h00);
        settle();
        `CHK(duty_b[17], 16'h0000)
        hw_shutdown_n = 1'b1;
        settle();
        lc_host_model_inst.wreg(lc_pkg::A_COMMIT, 8'h00);
        settle();
        `CHK({duty_a[0], duty_b[0]}, 32'h1234_5678)
        `CHK({duty_a[17], duty_b[17]}, 32'hbeef_dead)
        `CHK(full_on[0], 1'b1)
        chk_rd(8'h02, 8'h12);
        // scales and gain act without any commit
        lc_host_model_inst.wreg(lc_pkg::A_GAIN, 8'h02);
        lc_host_model_inst.wreg(lc_pkg::A_SC0, 8'h03);
        lc_host_model_inst.wreg(8'h4b, 8'h05);
        settle();
        `CHK(peak[0], 17'd16)
        lc_host_model_inst.wreg(8'h6c, 8'hff);
        lc_host_model_inst.wreg(lc_pkg::A_SCN, 8'hff);
        lc_host_model_inst.wreg(lc_pkg::A_GAIN, 8'hff);
        settle();
        `CHK(peak[17], 17'd130050)
        // short capture, then open capture replaces it, then disabled mode
        fault_raw = 18'h2a5c3;
        settle();
        lc_host_model_inst.wreg(lc_pkg::A_DET, 8'h02);
        settle();
        `CHK(det_kind, 1'b0)
        chk_rd(lc_pkg::A_FLT0, 8'hc3);
        chk_rd(lc_pkg::A_FLT1, 8'ha5);
        chk_rd(lc_pkg::A_FLT4, 8'h02);
        fault_raw = 18'h1003c;
        settle();
        lc_host_model_inst.wreg(lc_pkg::A_DET, 8'h03);
        settle();
        `CHK(det_kind, 1'b1)
        chk_rd(lc_pkg::A_FLT0, 8'h3c);
        chk_rd(lc_pkg::A_FLT4, 8'h01);
        fault_raw = 18'h0;
        settle();
        lc_host_model_inst.wreg(lc_pkg::A_DET, 8'h00);
        chk_rd(lc_pkg::A_FLT0, 8'h3c);
        chk_rd(8'h74, 8'h00);
        `CHK(n_det, 2)
        // over-threshold flag reads live
        over_temp = 1'b1;
        settle();
        lc_host_model_inst.temp_read(2'b01, 2'b10, d, v);
        `CHK({v, d}, 9'h152)
        // soft reset takes only the zero byte
        lc_host_model_inst.wreg(lc_pkg::A_RST, 8'h01);
        chk_rd(lc_pkg::A_GAIN, 8'hff);
        lc_host_model_inst.wreg(lc_pkg::A_RST, 8'h00);
        chk_rd(lc_pkg::A_GAIN, 8'h00);
        chk_rd(lc_pkg::A_PHASE, 8'h00);
        chk_rd(lc_pkg::A_DUTY0, 8'h00);
        settle();
        `CHK(full_on, 18'h3ffff)
        `CHK(peak[17], 17'd0)
        `CHK(outputs_on, 1'b0)
        // mid-run reset: outputs drop while held, defaults after release
        lc_host_model_inst.wreg(lc_pkg::A_GAIN, 8'h11);
        lc_host_model_inst.wreg(lc_pkg::A_CTRL, 8'h01);
        repeat (2) @(negedge clk_i);
        `CHK(outputs_on, 1'b1)
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK(outputs_on, 1'b0)
        rst_i = 1'b0;
        settle();
        `CHK(full_on, 18'h3ffff)
        chk_rd(lc_pkg::A_GAIN, 8'h00);
        finish_test();
    end
endmodule // test_lc_regs
